// [rtl/char_fifo.sv]
// parameterised first-in first-out buffer for the received line
// assumes synchronous active-low reset on the shared core clock
`timescale 1ns/100ps
`default_nettype none
module char_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 32
) (
    input  wire logic    i_clk,
    input  wire logic    i_rst_b,
    char_stream_if.snk   wr,
    char_stream_if.src   rd,
    output logic         o_empty
);
    localparam int AW = $clog2(DEPTH);
    logic [W:0]  mem [DEPTH];               // data plus last flag
    logic [AW-1:0] wp_q, rp_q;               // write and read pointers
    logic [AW:0]   cnt_q;                    // occupancy
    wire do_wr = wr.valid && wr.ready;       // accepted write
    wire do_rd = rd.valid && rd.ready;       // accepted read

    // room left: refuse only when every entry is taken
    assign wr.ready = (32'(cnt_q) < DEPTH);
    assign rd.valid = (cnt_q != '0);
    assign rd.data  = mem[rp_q][W-1:0];
    assign rd.last  = mem[rp_q][W];
    assign o_empty  = (cnt_q == '0);

    // storage writes
    always_ff @(posedge i_clk) begin
        if (do_wr) begin
            mem[wp_q] <= {wr.last, wr.data};
        end
    end

    // pointers and count
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (do_wr) wp_q <= (32'(wp_q) == DEPTH-1) ? '0 : wp_q + 1'b1;
            if (do_rd) rp_q <= (32'(rp_q) == DEPTH-1) ? '0 : rp_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule : char_fifo
`default_nettype wire

// [rtl/char_stream_if.sv]
// valid/ready character stream between the front end and its line buffer
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none
interface char_stream_if #(parameter int W = 8);
    logic         valid;    // source has a character
    logic         ready;    // sink takes it this cycle
    logic [W-1:0] data;     // character
    logic         last;     // character is a line terminator and closes the message
    modport src (output valid, output data, output last, input ready);
    modport snk (input valid, input data, input last, output ready);
endinterface : char_stream_if
`default_nettype wire

// [rtl/flow_pkg.sv]
// constants for the serial flow-control and command framing front end
// assumes one 250 MHz core clock and byte-wide characters from a uart
package flow_pkg;
    localparam int          DATA_W      = 8;        // character width
    localparam int          FIFO_DEPTH  = 32;       // line buffer depth in characters
    localparam logic [7:0]  CH_XON      = 8'h11;    // transmission-on
    localparam logic [7:0]  CH_XOFF     = 8'h13;    // transmission-off
    localparam logic [7:0]  CH_CR       = 8'h0d;    // carriage return
    localparam logic [7:0]  CH_LF       = 8'h0a;    // line feed
    localparam logic [7:0]  CH_STAR     = 8'h2a;    // common command marker
    localparam logic [7:0]  CH_SPACE    = 8'h20;    // keyword / parameter separator
    localparam logic [7:0]  CH_SEMI     = 8'h3b;    // message unit separator
    localparam logic [7:0]  CH_QUERY    = 8'h3f;    // query marker
    localparam int          FLOW_SW_BIT = 2;        // switch bit that disables flow control
    localparam int          SW_W        = 6;        // width of the switch bank
endpackage : flow_pkg

// [rtl/serial_flow_front.sv]
// serial front end: paces the host with transmission-on/off, shapes the echo,
// buffers a line and frames it into message units for the parser behind it
// assumes a uart delivers received bytes as single-cycle strobes and takes
// transmit bytes with a valid/ready handshake; the parser drains units
//
// How it works
// - send transmission-on to let host transmit
// - send transmission-off to pause the host
// - terminator answered xoff+cr, or xoff alone
// - later send cr lf only when echo on
// - message is units closed by line terminator
// - space separates keyword from parameter
// - asterisk first marks a common command
// - accept program message at any moment
// - queries flagged so replies can follow
// - cr or lf ends line, starts parsing
// - switch bit 2 low with jumper set enables flow control
`timescale 1ns/100ps
`default_nettype none
module serial_flow_front #(
    parameter int W     = flow_pkg::DATA_W,
    parameter int DEPTH = flow_pkg::FIFO_DEPTH
) (
    input  wire logic                   I_CORE_CLK,
    input  wire logic                   I_RST_B,
    input  wire logic                   I_RX_VALID,     // received byte strobe
    input  wire logic [W-1:0]           I_RX_DATA,      // received byte
    input  wire logic                   I_TX_READY,     // uart takes transmit byte
    input  wire logic                   I_ECHO_EN,      // echo mode
    input  wire logic                   I_CFG_JUMPER,   // configuration jumper (pin)
    input  wire logic [flow_pkg::SW_W-1:0] I_SWITCH,    // address switch bank (pins)
    input  wire logic                   I_UNIT_READY,   // parser takes a character
    output logic                        O_TX_VALID,     // transmit byte valid
    output logic [W-1:0]                O_TX_DATA,      // transmit byte
    output logic                        O_UNIT_VALID,   // framed character valid
    output logic [W-1:0]                O_UNIT_DATA,    // framed character
    output logic                        O_UNIT_LAST,    // closes a message unit
    output logic                        O_UNIT_END,     // closes the whole message
    output logic                        O_UNIT_COMMON,  // unit is a common command
    output logic                        O_UNIT_QUERY,   // unit is a query
    output logic                        O_UNIT_PARAM,   // character is a parameter
    output logic                        O_OVERFLOW      // byte lost, buffer full
);
    // states of the transmit sequencer
    typedef enum logic [2:0] {
        TX_IDLE, TX_XOFF, TX_CR1, TX_WAIT, TX_CR2, TX_LF, TX_XON
    } tx_e;

    char_stream_if #(.W(W)) in_s ();          // bytes into the buffer
    char_stream_if #(.W(W)) out_s ();         // bytes out of the buffer
    logic          buf_empty;                 // buffer drained

    logic [1:0]                   jmp_sync_q;      // jumper synchroniser
    logic [flow_pkg::SW_W-1:0]    sw_meta_q;       // switch first stage
    logic [flow_pkg::SW_W-1:0]    sw_sync_q;       // switch second stage
    tx_e           tx_q, tx_d;                // transmit sequencer
    logic          echo_cap_q;                // echo setting at terminator
    logic          line_open_q;               // terminator still in buffer
    logic          prev_term_q;               // last byte was a terminator
    logic          xon_sent_q;                // power-up grant done
    logic          unit_start_q;              // next char starts a unit
    logic          common_q, query_q, param_q;// unit classification
    logic          uv_q, ul_q, ue_q;          // output stage flags
    logic [W-1:0]  ud_q;                      // output stage data
    logic          ovf_q;                     // overflow pulse
    logic          txv_q;
    logic [W-1:0]  txd_q;

    // flow control enabled only with jumper and switch bit clear
    wire flow_en  = jmp_sync_q[1] && !sw_sync_q[flow_pkg::FLOW_SW_BIT];
    wire is_term  = (I_RX_DATA == flow_pkg::CH_CR) || (I_RX_DATA == flow_pkg::CH_LF);
    wire new_term = I_RX_VALID && is_term && !prev_term_q;  // pair cr lf counts once
    wire store    = I_RX_VALID && !(is_term && prev_term_q);
    wire tx_take  = txv_q && I_TX_READY;
    wire in_term  = (out_s.data == flow_pkg::CH_CR) || (out_s.data == flow_pkg::CH_LF);
    wire in_sep   = (out_s.data == flow_pkg::CH_SEMI);
    wire stage_free = !uv_q || I_UNIT_READY;
    wire pop      = out_s.valid && stage_free;

    // bytes offered to the buffer at any moment; dropped when it is full
    assign in_s.valid = store;
    assign in_s.data  = is_term ? flow_pkg::CH_LF : I_RX_DATA;
    assign in_s.last  = is_term;
    assign out_s.ready = stage_free;

    char_fifo #(.W(W), .DEPTH(DEPTH)) u_buf (
        .i_clk   (I_CORE_CLK),
        .i_rst_b (I_RST_B),
        .wr      (in_s),
        .rd      (out_s),
        .o_empty (buf_empty)
    );

    // two-stage synchronisers for pin inputs
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_B) begin
            jmp_sync_q <= '0;
            sw_meta_q  <= '0;
            sw_sync_q  <= '0;
        end else begin
            jmp_sync_q <= {jmp_sync_q[0], I_CFG_JUMPER};
            sw_meta_q  <= I_SWITCH;
            sw_sync_q  <= sw_meta_q;
        end
    end

    // transmit sequencer next state
    always_comb begin
        tx_d = tx_q;
        unique case (tx_q)
            TX_IDLE: begin
                if (new_term && flow_en) tx_d = TX_XOFF;
                else if (flow_en && !xon_sent_q) tx_d = TX_XON;
            end
            TX_XOFF: if (tx_take) tx_d = echo_cap_q ? TX_CR1 : TX_WAIT;
            TX_CR1:  if (tx_take) tx_d = TX_WAIT;
            // hold the host off until the line has been forwarded
            TX_WAIT: if (!line_open_q && buf_empty) tx_d = echo_cap_q ? TX_CR2 : TX_XON;
            TX_CR2:  if (tx_take) tx_d = TX_LF;
            TX_LF:   if (tx_take) tx_d = TX_XON;
            TX_XON:  if (tx_take) tx_d = TX_IDLE;
        endcase
    end

    logic [W-1:0] tx_byte_d;                  // byte for the state being entered

    // transmit byte for each state
    always_comb begin
        unique case (tx_d)
            TX_XOFF: tx_byte_d = flow_pkg::CH_XOFF;
            TX_CR1,
            TX_CR2:  tx_byte_d = flow_pkg::CH_CR;
            TX_LF:   tx_byte_d = flow_pkg::CH_LF;
            TX_XON:  tx_byte_d = flow_pkg::CH_XON;
            default: tx_byte_d = '0;
        endcase
    end
    wire tx_busy_d = (tx_d != TX_IDLE) && (tx_d != TX_WAIT);

    // sequencer and line bookkeeping
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_B) begin
            tx_q        <= TX_IDLE;
            txv_q       <= 1'b0;
            txd_q       <= '0;
            echo_cap_q  <= 1'b0;
            line_open_q <= 1'b0;
            prev_term_q <= 1'b0;
            xon_sent_q  <= 1'b0;
            ovf_q       <= 1'b0;
        end else begin
            tx_q  <= tx_d;
            txv_q <= tx_busy_d;
            txd_q <= tx_byte_d;
            if (I_RX_VALID) prev_term_q <= is_term;
            if (new_term && tx_q == TX_IDLE) echo_cap_q <= I_ECHO_EN;
            // set beats clear: a new terminator keeps the line open
            if (new_term) line_open_q <= 1'b1;
            else if (pop && out_s.last) line_open_q <= 1'b0;
            if (tx_q == TX_XON && tx_take) xon_sent_q <= 1'b1;
            ovf_q <= store && !in_s.ready;
        end
    end

    // framing of the buffered line into message units
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_B) begin
            unit_start_q <= 1'b1;
            common_q     <= 1'b0;
            query_q      <= 1'b0;
            param_q      <= 1'b0;
            uv_q         <= 1'b0;
            ud_q         <= '0;
            ul_q         <= 1'b0;
            ue_q         <= 1'b0;
        end else begin
            if (stage_free) uv_q <= out_s.valid;
            if (pop) begin
                ud_q <= out_s.data;
                ul_q <= in_term || in_sep;
                ue_q <= in_term;
                unit_start_q <= in_term || in_sep;
                if (unit_start_q) begin
                    common_q <= (out_s.data == flow_pkg::CH_STAR);
                    query_q  <= 1'b0;
                    param_q  <= 1'b0;
                end
                if (out_s.data == flow_pkg::CH_QUERY && !param_q)
                    query_q <= 1'b1;
                if (out_s.data == flow_pkg::CH_SPACE && !unit_start_q)
                    param_q <= 1'b1;
            end
        end
    end

    assign O_TX_VALID    = txv_q;
    assign O_TX_DATA     = txd_q;
    assign O_UNIT_VALID  = uv_q;
    assign O_UNIT_DATA   = ud_q;
    assign O_UNIT_LAST   = ul_q;
    assign O_UNIT_END    = ue_q;
    assign O_UNIT_COMMON = common_q;
    assign O_UNIT_QUERY  = query_q;
    assign O_UNIT_PARAM  = param_q;
    assign O_OVERFLOW    = ovf_q;
endmodule : serial_flow_front
`default_nettype wire

// [verification/flow_front_checker.sv]
// port checker for the serial front end
// assumes it is bound onto serial_flow_front, one clock domain
`timescale 1ns/100ps
`default_nettype none
module flow_front_checker #(parameter int W = 8) (
    input wire logic         I_CORE_CLK,
    input wire logic         I_RST_B,
    input wire logic         I_RX_VALID,
    input wire logic         I_TX_READY,
    input wire logic         I_UNIT_READY,
    input wire logic         O_TX_VALID,
    input wire logic [W-1:0] O_TX_DATA,
    input wire logic         O_UNIT_VALID,
    input wire logic [W-1:0] O_UNIT_DATA,
    input wire logic         O_UNIT_LAST,
    input wire logic         O_UNIT_END,
    input wire logic         O_OVERFLOW
);
    // single domain, synchronous reset
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_B);
    // the only bytes the pacing logic may send
    wire tx_code = O_TX_DATA inside {flow_pkg::CH_XON, flow_pkg::CH_XOFF,
                                     flow_pkg::CH_CR, flow_pkg::CH_LF};
    chk_tx_holds: assert property (
        O_TX_VALID && !I_TX_READY |=> O_TX_VALID && $stable(O_TX_DATA))
        else $error("transmit byte changed before taken");
    chk_unit_holds: assert property (
        O_UNIT_VALID && !I_UNIT_READY |=> O_UNIT_VALID && $stable({O_UNIT_DATA, O_UNIT_LAST}))
        else $error("unit char changed before taken");
    chk_tx_codes: assert property (O_TX_VALID |-> tx_code)
        else $error("unexpected transmit byte");
    chk_end_marks: assert property (
        O_UNIT_VALID && O_UNIT_END |-> O_UNIT_LAST && O_UNIT_DATA == flow_pkg::CH_LF)
        else $error("message end not a terminator");
    chk_semi_last: assert property (
        O_UNIT_VALID && O_UNIT_DATA == flow_pkg::CH_SEMI |-> O_UNIT_LAST && !O_UNIT_END)
        else $error("unit separator not marked");
    chk_term_end: assert property (
        O_UNIT_VALID && O_UNIT_DATA == flow_pkg::CH_LF |-> O_UNIT_END)
        else $error("terminator not closing message");
    chk_ovf_cause: assert property (O_OVERFLOW |-> $past(I_RX_VALID))
        else $error("overflow without a byte");
    chk_reset_quiet: assert property (
        $past(!I_RST_B) |-> !O_TX_VALID && !O_UNIT_VALID && !O_OVERFLOW)
        else $error("output active after reset");
endmodule : flow_front_checker
`default_nettype wire

// [verification/host_model.sv]
// host model: paced serial sender and reader of the device's bytes
// assumes the core clock; drives its outputs at the falling edge
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input  wire logic       i_clk,
    input  wire logic       i_flow_en,  // host honours pacing
    input  wire logic       i_slow,     // stall the transmit side
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_data,
    output logic            o_tx_ready,
    output logic            o_rx_valid,
    output logic [7:0]      o_rx_data
);
    logic [7:0] got[$];       // bytes taken from the device
    logic       perm = 1'b0;  // may send
    initial begin
        o_tx_ready = 1'b0;
        o_rx_valid = 1'b0;
        o_rx_data  = 8'h00;
    end
    // ready every other cycle when slow
    always @(negedge i_clk) o_tx_ready <= !i_slow || !o_tx_ready;
    // collect bytes; on grants permission, off withdraws it
    always @(posedge i_clk) begin
        if (i_tx_valid && o_tx_ready) begin
            got.push_back(i_tx_data);
            if (i_tx_data == flow_pkg::CH_XON) perm <= 1'b1;
            if (i_tx_data == flow_pkg::CH_XOFF) perm <= 1'b0;
        end
    end
    // back to back strobes; idle data toggles so it never looks held
    // lines start with the command itself: no address phase on this link
    task automatic send(input string s);
        for (int i = 0; i < s.len(); i++) begin
            @(negedge i_clk);
            while (i_flow_en && !perm) begin
                o_rx_valid <= 1'b0;
                o_rx_data  <= ~o_rx_data;
                @(negedge i_clk);
            end
            o_rx_valid <= 1'b1;
            o_rx_data  <= s[i];
        end
        @(negedge i_clk);
        o_rx_valid <= 1'b0;
        o_rx_data  <= ~o_rx_data;
    endtask : send
endmodule : host_model
`default_nettype wire

// [verification/serial_flow_front_tb.sv]
// bench: host model on the serial side, parser side driven here
// assumes flow_pkg and the front end's hand-over timing
`timescale 1ns/100ps
`default_nettype none
module serial_flow_front_tb;
    localparam int W = flow_pkg::DATA_W;
    logic         clk = 1'b0, rst_b = 1'b0, echo = 1'b1, flow_off = 1'b0;
    logic         slow = 1'b0, stall = 1'b0, park = 1'b0, tog = 1'b0, jmp = 1'b1;
    logic         rx_v, tx_v, tx_rdy, u_v, u_last, u_end, u_com, u_qry, u_par, ovf;
    logic [W-1:0] rx_d, tx_d, u_d;
    logic [12:0]  uq[$];      // taken chars with flags
    int           ovf_n = 0, bad_count = 0, samples_checked = 0, cyc = 0;
    wire          unit_rdy = !park && (!stall || tog); // parser pace
    serial_flow_front u_serial_flow_front (
        .I_CORE_CLK(clk), .I_RST_B(rst_b), .I_RX_VALID(rx_v), .I_RX_DATA(rx_d),
        .I_TX_READY(tx_rdy), .I_ECHO_EN(echo), .I_CFG_JUMPER(jmp),
        .I_SWITCH({3'h0, flow_off, 2'h0}), .I_UNIT_READY(unit_rdy), .O_TX_VALID(tx_v),
        .O_TX_DATA(tx_d), .O_UNIT_VALID(u_v), .O_UNIT_DATA(u_d), .O_UNIT_LAST(u_last),
        .O_UNIT_END(u_end), .O_UNIT_COMMON(u_com), .O_UNIT_QUERY(u_qry),
        .O_UNIT_PARAM(u_par), .O_OVERFLOW(ovf));
    host_model u_host_model (.i_clk(clk), .i_flow_en(!flow_off && jmp), .i_slow(slow),
        .i_tx_valid(tx_v), .i_tx_data(tx_d), .o_tx_ready(tx_rdy), .o_rx_valid(rx_v),
        .o_rx_data(rx_d));
    initial forever #2 clk = ~clk;
    always @(negedge clk) tog <= !tog;
    // record taken chars, count drops, cut a hang short
    always @(posedge clk) begin
        if (u_v && unit_rdy) uq.push_back({u_last, u_end, u_com, u_qry, u_par, u_d});
        if (ovf) ovf_n++;
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic check(input logic [12:0] seen, input logic [12:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // wait for n transmit bytes and m chars, then let stragglers show
    task automatic settle(input int n, input int m);
        for (int i = 0; i < 2000 && (u_host_model.got.size() < n || uq.size() < m); i++)
            @(negedge clk);
        repeat (20) @(negedge clk);
    endtask : settle
    // echo on, slow host, stalling parser, common query
    task automatic t_echo_line();
        logic [7:0] exp[5];
        exp = '{flow_pkg::CH_XOFF, flow_pkg::CH_CR, flow_pkg::CH_CR, flow_pkg::CH_LF,
                flow_pkg::CH_XON};
        slow = 1'b1;
        stall = 1'b1;
        u_host_model.send("*IDN?\015");
        settle(6, 6);
        for (int i = 0; i < 5; i++) check(13'(u_host_model.got[i + 1]), 13'(exp[i]));
        check(uq[2], {5'b00100, 8'h44});
        check(uq[5], {5'b11110, flow_pkg::CH_LF});
    endtask : t_echo_line
    // echo off, cr lf pair, parameter and two units
    task automatic t_quiet_line();
        uq.delete();
        echo = 1'b0;
        slow = 1'b0;
        stall = 1'b0;
        u_host_model.send("VOLT 5;X\015\012");
        settle(8, 9);
        check(13'(u_host_model.got[6]), 13'(flow_pkg::CH_XOFF));
        check(13'(u_host_model.got[7]), 13'(flow_pkg::CH_XON));
        check(13'(u_host_model.got.size()), 13'd8);
        check(13'(uq.size()), 13'd9);
        check(uq[5], {5'b00001, 8'h35});
        check(uq[6] & 13'h18ff, {5'b10000, flow_pkg::CH_SEMI});
        check(uq[8], {5'b11000, flow_pkg::CH_LF});
    endtask : t_quiet_line
    // pacing off; parser parked until the buffer refuses
    task automatic t_flow_off();
        uq.delete();
        flow_off = 1'b1;
        park = 1'b1;
        repeat (4) @(negedge clk);
        u_host_model.send("AAAAAAAAAAAAAAAAAAAAAAAAAAAAAAAAAA");
        park = 1'b0;
        u_host_model.send("\015");
        settle(8, 35 - ovf_n);
        check(13'(ovf_n != 0), 13'd1);
        check(13'(uq.size() + ovf_n), 13'd35);
        check(13'(u_host_model.got.size()), 13'd8);
        check(uq[$], {5'b11000, flow_pkg::CH_LF});
        // switch bit clear again but jumper pulled: pacing must stay off
        flow_off = 1'b0;
        jmp = 1'b0;
        repeat (4) @(negedge clk);
        u_host_model.send("B\015");
        settle(8, 37 - ovf_n);
        check(13'(u_host_model.got.size()), 13'd8);
        check(uq[$ - 1], {5'b00000, 8'h42});
    endtask : t_flow_off
    task automatic print_verdict();
        $display("compared %0d, mismatched %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    // reset, power-up grant, then the scenarios
    initial begin
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        settle(1, 0);
        check(13'(u_host_model.got[0]), 13'(flow_pkg::CH_XON));
        t_echo_line();
        t_quiet_line();
        t_flow_off();
        print_verdict();
    end
endmodule : serial_flow_front_tb
bind serial_flow_front flow_front_checker #(.W(W)) u_flow_front_checker (
    .I_CORE_CLK(I_CORE_CLK), .I_RST_B(I_RST_B), .I_RX_VALID(I_RX_VALID),
    .I_TX_READY(I_TX_READY), .I_UNIT_READY(I_UNIT_READY), .O_TX_VALID(O_TX_VALID),
    .O_TX_DATA(O_TX_DATA), .O_UNIT_VALID(O_UNIT_VALID), .O_UNIT_DATA(O_UNIT_DATA),
    .O_UNIT_LAST(O_UNIT_LAST), .O_UNIT_END(O_UNIT_END), .O_OVERFLOW(O_OVERFLOW));
`default_nettype wire
